// *** pfps_pkg.sv ***
package pfps_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_TMR3_MODE = 8'h00;
	localparam logic [7:0] OFS_TMR3_IOCTL = 8'h01;
	localparam logic [7:0] OFS_TMR3_CTRL = 8'h02;
	localparam logic [7:0] OFS_PULSE_EN = 8'h03;
	localparam logic [7:0] OFS_PULSE_NEXT = 8'h04;
	localparam logic [7:0] OFS_PULSE_OUT = 8'h05;
	localparam logic [7:0] OFS_P2_DIR = 8'h06;
	localparam logic [7:0] OFS_P2_DATA = 8'h07;
	localparam logic [7:0] OFS_P6_DIR = 8'h08;
	localparam logic [7:0] OFS_P6_DATA = 8'h09;
	localparam logic [7:0] OFS_DMA_END = 8'h0A;
	localparam logic [7:0] OFS_PIN_STAT = 8'h0B;

	// ------------------------------------------------------------
	// Field positions and codes
	// ------------------------------------------------------------
	localparam int P21_BIT = 1;
	localparam int END0_EN_BIT = 0;
	localparam int END1_EN_BIT = 1;
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_PWM2 = 4'h3;
	localparam logic [2:0] CLR_BY_OWN_B = 3'h2;
	localparam logic [1:0] IOB_CAPTURE_HI = 2'h2;
	localparam logic [2:0] OPMODE_EXT_LO = 3'h4;
	localparam logic [2:0] OPMODE_EXT_HI = 3'h6;

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] RST_REG8 = 8'h00;
	localparam logic [3:0] RST_REG4 = 4'h0;
	localparam logic [2:0] RST_REG3 = 3'h0;
	localparam logic [1:0] RST_REG2 = 2'h0;
	localparam int SYNC_STAGES = 2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		PFPS_FN_PORT_IN = 4'b0001,
		PFPS_FN_PORT_OUT = 4'b0010,
		PFPS_FN_PULSE = 4'b0100,
		PFPS_FN_TIMER = 4'b1000
	} pfps_p21_fn_t;

	typedef struct packed {
		logic [3:0] mode;
		logic [3:0] b_io;
		logic [2:0] clr;
	} pfps_tmr_cfg_t;

	typedef struct packed {
		logic out;
		logic oe;
	} pfps_pin_t;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} pfps_pin6_t;

endpackage

// *** pfps_sync.sv ***
`timescale 1ns/1ps
module pfps_sync import pfps_pkg::*; #(
	parameter int WIDTH = 1
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] q_reg;
	logic [WIDTH-1:0] s1_next;
	logic [WIDTH-1:0] q_next;

	generate
		if (WIDTH < 1) begin : g_chk
			$error("pfps_sync width must be at least one");
		end
	endgenerate

	// Two stages; first stage only feeds the second
	always_comb begin
		s1_next = ce ? d : s1_reg;
		q_next = ce ? s1_reg : q_reg;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= '0;
			q_reg <= '0;
		end else begin
			s1_reg <= s1_next;
			q_reg <= q_next;
		end
	end

	assign q = q_reg;

endmodule

// *** pfps_top.sv ***
`timescale 1ns/1ps
//
// Contract
// - P21 function from timer, pulse, direction
// - Normal-mode compare codes give timer output
// - PWM mode 2 output unless I/O code xx00 or clear 010
// - Otherwise direction and pulse enable pick
// - Capture input in normal mode, code 10xx
// - Timer output beats pulse output
// - Next data transfers into pulse-enabled bits on each trigger while ce is high
//
module pfps_top import pfps_pkg::*; #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 8
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	// Operating mode strap pins
	input wire logic [2:0] opmode_pin,
	// Timer channel 3 and pulse trigger (same clock)
	input wire logic timer3_b_out,
	input wire logic pulse_trigger,
	output logic timer3_capture_b,
	// DMA and bus controller (same clock)
	input wire logic dma0_end,
	input wire logic dma1_end,
	input wire logic chip_select_four_n,
	input wire logic chip_select_five_n,
	output logic dma0_request,
	output logic dma1_request,
	// Port 2 bit 1 pin
	input wire logic p21_in,
	output pfps_pin_t p21,
	// Port 6 bits 3..0 pins
	input wire logic [3:0] p6_in,
	output pfps_pin6_t p6
);

	generate
		if (DATA_W != 8 || ADDR_W < 8) begin : g_chk
			$error("pfps_top needs 8-bit data and 8+ address bits");
		end
	endgenerate

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Timer owns the pin for output
	function automatic logic tmr_owns(input pfps_tmr_cfg_t c);
		logic r;
		r = 1'b0;
		if (c.mode == MODE_NORMAL) begin
			r = !c.b_io[3] && (c.b_io[1:0] != 2'h0);
		end else if (c.mode == MODE_PWM2) begin
			r = (c.b_io[1:0] != 2'h0) && (c.clr != CLR_BY_OWN_B);
		end
		return r;
	endfunction

	// Port 2 bit 1 function
	function automatic pfps_p21_fn_t p21_fn(input pfps_tmr_cfg_t c,
			input logic dir, input logic pen);
		pfps_p21_fn_t f;
		if (tmr_owns(c)) begin
			f = PFPS_FN_TIMER;
		end else if (!dir) begin
			f = PFPS_FN_PORT_IN;
		end else if (!pen) begin
			f = PFPS_FN_PORT_OUT;
		end else begin
			f = PFPS_FN_PULSE;
		end
		return f;
	endfunction

	// Modes 4 to 6 route chip selects
	function automatic logic ext_mode(input logic [2:0] m);
		return (m >= OPMODE_EXT_LO) && (m <= OPMODE_EXT_HI);
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [7:0] pin_raw;
	logic [7:0] pin_sync;
	assign pin_raw = {opmode_pin, p6_in, p21_in};

	pfps_sync #(.WIDTH(8)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.d(pin_raw),
		.q(pin_sync)
	);

	logic p21_s;
	logic [3:0] p6_s;
	logic [2:0] opmode_s;
	assign p21_s = pin_sync[0];
	assign p6_s = pin_sync[4:1];
	assign opmode_s = pin_sync[7:5];

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	pfps_tmr_cfg_t tcfg_reg, tcfg_next;
	logic [7:0] pulse_enable_low_reg, pulse_enable_low_next;
	logic [7:0] pulse_next_data_reg, pulse_next_data_next;
	logic [7:0] pulse_output_data_reg, pulse_output_data_next;
	logic [7:0] p2_dir_reg, p2_dir_next;
	logic [7:0] p2_data_reg, p2_data_next;
	logic [3:0] p6_dir_reg, p6_dir_next;
	logic [3:0] p6_data_reg, p6_data_next;
	logic [1:0] dma_end_control_reg, dma_end_control_next;
	logic wen;

	assign wen = ce && wr;

	// Register writes and pulse data transfer
	always_comb begin
		tcfg_next = tcfg_reg;
		pulse_enable_low_next = pulse_enable_low_reg;
		pulse_next_data_next = pulse_next_data_reg;
		pulse_output_data_next = pulse_output_data_reg;
		p2_dir_next = p2_dir_reg;
		p2_data_next = p2_data_reg;
		p6_dir_next = p6_dir_reg;
		p6_data_next = p6_data_reg;
		dma_end_control_next = dma_end_control_reg;
		if (wen) begin
			case (addr[7:0])
				OFS_TMR3_MODE: tcfg_next.mode = wdata[3:0];
				OFS_TMR3_IOCTL: tcfg_next.b_io = wdata[3:0];
				OFS_TMR3_CTRL: tcfg_next.clr = wdata[2:0];
				OFS_PULSE_EN: pulse_enable_low_next = wdata;
				OFS_PULSE_NEXT: pulse_next_data_next = wdata;
				OFS_PULSE_OUT: pulse_output_data_next = wdata;
				OFS_P2_DIR: p2_dir_next = wdata;
				OFS_P2_DATA: p2_data_next = wdata;
				OFS_P6_DIR: p6_dir_next = wdata[3:0];
				OFS_P6_DATA: p6_data_next = wdata[3:0];
				OFS_DMA_END: dma_end_control_next = wdata[1:0];
				default: ;
			endcase
		end
		// Trigger wins over a same-cycle write in enabled bits; pin use is ignored
		if (ce && pulse_trigger) begin
			pulse_output_data_next = (pulse_output_data_next &
				~pulse_enable_low_reg) |
				(pulse_next_data_reg & pulse_enable_low_reg);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tcfg_reg <= '{mode: RST_REG4, b_io: RST_REG4, clr: RST_REG3};
			pulse_enable_low_reg <= RST_REG8;
			pulse_next_data_reg <= RST_REG8;
			pulse_output_data_reg <= RST_REG8;
			p2_dir_reg <= RST_REG8;
			p2_data_reg <= RST_REG8;
			p6_dir_reg <= RST_REG4;
			p6_data_reg <= RST_REG4;
			dma_end_control_reg <= RST_REG2;
		end else begin
			tcfg_reg <= tcfg_next;
			pulse_enable_low_reg <= pulse_enable_low_next;
			pulse_next_data_reg <= pulse_next_data_next;
			pulse_output_data_reg <= pulse_output_data_next;
			p2_dir_reg <= p2_dir_next;
			p2_data_reg <= p2_data_next;
			p6_dir_reg <= p6_dir_next;
			p6_data_reg <= p6_data_next;
			dma_end_control_reg <= dma_end_control_next;
		end
	end

	// ------------------------------------------------------------
	// Pin function selection
	// ------------------------------------------------------------
	pfps_p21_fn_t fn_now;
	logic capture_sel;
	logic end0_en;
	logic end1_en;
	logic ext_now;
	pfps_pin_t p21_reg, p21_next;
	pfps_pin6_t p6_reg, p6_next;
	logic capture_reg, capture_next;
	logic req0_reg, req0_next;
	logic req1_reg, req1_next;

	assign fn_now = p21_fn(tcfg_reg, p2_dir_reg[P21_BIT],
		pulse_enable_low_reg[P21_BIT]);
	assign capture_sel = (tcfg_reg.mode == MODE_NORMAL) &&
		(tcfg_reg.b_io[3:2] == IOB_CAPTURE_HI);
	assign end0_en = dma_end_control_reg[END0_EN_BIT];
	assign end1_en = dma_end_control_reg[END1_EN_BIT];
	assign ext_now = ext_mode(opmode_s);

	// Next pin drive, capture and request levels
	always_comb begin
		p21_next = p21_reg;
		p6_next = p6_reg;
		capture_next = capture_reg;
		req0_next = req0_reg;
		req1_next = req1_reg;
		if (ce) begin
			case (fn_now)
				PFPS_FN_TIMER: p21_next = '{out: timer3_b_out, oe: 1'b1};
				PFPS_FN_PULSE: p21_next = '{
					out: pulse_output_data_reg[P21_BIT], oe: 1'b1};
				PFPS_FN_PORT_OUT: p21_next = '{
					out: p2_data_reg[P21_BIT], oe: 1'b1};
				default: p21_next = '{out: 1'b0, oe: 1'b0};
			endcase
			// Capture runs beside port input
			capture_next = capture_sel ? p21_s : 1'b0;
			// Bit 3: end output or port
			if (end1_en) begin
				p6_next.out[3] = !dma1_end;
				p6_next.oe[3] = 1'b1;
			end else begin
				p6_next.out[3] = p6_data_reg[3];
				p6_next.oe[3] = p6_dir_reg[3];
			end
			// Bit 2: port only, request fed below
			p6_next.out[2] = p6_data_reg[2];
			p6_next.oe[2] = p6_dir_reg[2];
			// Bit 1: end output, chip select or port
			if (end0_en) begin
				p6_next.out[1] = !dma0_end;
				p6_next.oe[1] = 1'b1;
			end else begin
				p6_next.out[1] = ext_now ? chip_select_five_n :
					p6_data_reg[1];
				p6_next.oe[1] = p6_dir_reg[1];
			end
			// Bit 0: chip select or port
			p6_next.out[0] = ext_now ? chip_select_four_n :
				p6_data_reg[0];
			p6_next.oe[0] = p6_dir_reg[0];
			req0_next = p6_s[0];
			req1_next = p6_s[2];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			p21_reg <= '{out: 1'b0, oe: 1'b0};
			p6_reg <= '{out: 4'h0, oe: 4'h0};
			capture_reg <= 1'b0;
			req0_reg <= 1'b0;
			req1_reg <= 1'b0;
		end else begin
			p21_reg <= p21_next;
			p6_reg <= p6_next;
			capture_reg <= capture_next;
			req0_reg <= req0_next;
			req1_reg <= req1_next;
		end
	end

	assign p21 = p21_reg;
	assign p6 = p6_reg;
	assign timer3_capture_b = capture_reg;
	assign dma0_request = req0_reg;
	assign dma1_request = req1_reg;

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	logic [7:0] rdata_reg, rdata_next;

	// Read data one cycle after the strobe, held while ce is low, else zero
	always_comb begin
		rdata_next = 8'h00;
		if (ce && rd) begin
			case (addr[7:0])
				OFS_TMR3_MODE: rdata_next = {4'h0, tcfg_reg.mode};
				OFS_TMR3_IOCTL: rdata_next = {4'h0, tcfg_reg.b_io};
				OFS_TMR3_CTRL: rdata_next = {5'h00, tcfg_reg.clr};
				OFS_PULSE_EN: rdata_next = pulse_enable_low_reg;
				OFS_PULSE_NEXT: rdata_next = pulse_next_data_reg;
				OFS_PULSE_OUT: rdata_next = pulse_output_data_reg;
				OFS_P2_DIR: rdata_next = p2_dir_reg;
				OFS_P2_DATA: rdata_next = p2_data_reg;
				OFS_P6_DIR: rdata_next = {4'h0, p6_dir_reg};
				OFS_P6_DATA: rdata_next = {4'h0, p6_data_reg};
				OFS_DMA_END: rdata_next = {6'h00, dma_end_control_reg};
				OFS_PIN_STAT: rdata_next = {fn_now[3:1], p6_s, p21_s};
				default: rdata_next = 8'h00;
			endcase
		end else if (!ce) begin
			rdata_next = rdata_reg;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign rdata = rdata_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_cmp_out_pin: assert property (@(posedge clk) disable iff (!nrst)
		ce && tcfg_reg.mode == 4'h0 && !tcfg_reg.b_io[3] &&
		tcfg_reg.b_io[1:0] != 2'h0 |=> p21.oe &&
		p21.out == $past(timer3_b_out))
		else $error("compare output not on pin");
	a_pwm2_out_pin: assert property (@(posedge clk) disable iff (!nrst)
		ce && tcfg_reg.mode == 4'h3 && tcfg_reg.b_io[1:0] != 2'h0 &&
		tcfg_reg.clr != 3'h2 |=> p21.oe && p21.out == $past(timer3_b_out))
		else $error("pwm2 output not on pin");
	a_pwm2_clear_falls: assert property (@(posedge clk)
		disable iff (!nrst)
		ce && tcfg_reg.mode == 4'h3 && tcfg_reg.clr == 3'h2 &&
		!p2_dir_reg[1] |=> !p21.oe)
		else $error("pwm2 with clear 010 still drives");
	a_port_in_float: assert property (@(posedge clk) disable iff (!nrst)
		ce && !tmr_owns(tcfg_reg) && !p2_dir_reg[1] |=> !p21.oe)
		else $error("port input drives pin");
	a_pulse_on_pin: assert property (@(posedge clk) disable iff (!nrst)
		ce && !tmr_owns(tcfg_reg) && p2_dir_reg[1] &&
		pulse_enable_low_reg[1] |=> p21.oe &&
		p21.out == $past(pulse_output_data_reg[1]))
		else $error("pulse output missing");
	a_timer_over_pulse: assert property (@(posedge clk)
		disable iff (!nrst)
		ce && tmr_owns(tcfg_reg) && p2_dir_reg[1] &&
		pulse_enable_low_reg[1] |=> p21.out == $past(timer3_b_out))
		else $error("pulse output beat timer");
	a_capture_feed: assert property (@(posedge clk) disable iff (!nrst)
		ce && tcfg_reg.mode == 4'h0 && tcfg_reg.b_io[3:2] == 2'h2
		|=> timer3_capture_b == $past(p21_s))
		else $error("capture input not fed");
	a_pulse_xfer: assert property (@(posedge clk) disable iff (!nrst)
		ce && pulse_trigger && pulse_enable_low_reg[1] && tmr_owns(tcfg_reg)
		|=> pulse_output_data_reg[1] == $past(pulse_next_data_reg[1]))
		else $error("next data not transferred");
	a_tend_select: assert property (@(posedge clk) disable iff (!nrst)
		ce && dma_end_control_reg[1] ##1 ce && dma_end_control_reg[1]
		|=> p6.oe[3] && p6.out[3] == !$past(dma1_end))
		else $error("transfer end not on pin");
	a_req_feed: assert property (@(posedge clk) disable iff (!nrst)
		ce && p6_dir_reg[0] |=> dma0_request == $past(p6_s[0]) &&
		dma1_request == $past(p6_s[2]))
		else $error("request pin not fed");

endmodule

// *** pfps_pin_model.sv ***
`timescale 1ns/1ps
module pfps_pin_model import pfps_pkg::*; (
	// Pin drives from the block
	input wire pfps_pin_t p21,
	input wire pfps_pin6_t p6,
	// Levels forced by the outside world
	input wire logic ext21,
	input wire logic [3:0] ext6,
	// Resolved pin levels
	output logic p21_in,
	output logic [3:0] p6_in
);
	// ------------------------------------------------------------
	// Pin resolution
	// ------------------------------------------------------------
	// A driving block wins, else the outside level shows
	assign p21_in = p21.oe ? p21.out : ext21;
	assign p6_in = (p6.oe & p6.out) | (~p6.oe & ext6);
endmodule

// *** tb_pfps_top.sv ***
`timescale 1ns/1ps
module tb_pfps_top import pfps_pkg::*;;
	// ------------------------------------------------------------
	// Stimulus and observation signals
	// ------------------------------------------------------------
	logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, m;
	logic [2:0] opmode_pin = 3'h7;
	logic timer3_b_out = 1'b0, pulse_trigger = 1'b0, ext21 = 1'b0;
	logic dma0_end = 1'b0, dma1_end = 1'b0;
	logic sel_four_n = 1'b1, sel_five_n = 1'b1;
	logic [3:0] ext6 = 4'h0, p6_in;
	logic cap, req0, req1, p21_in, rd_d = 1'b0;
	pfps_pin_t p21;
	pfps_pin6_t p6;
	int mismatches = 0, checks_done = 0, cycles = 0;
	logic [7:0] exp_q[$], msk_q[$];
	logic [7:0] en, nd, pod, pd;
	logic [7:0] wa[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h09};
	logic [7:0] wm[7] = '{8'h0F, 8'h0F, 8'h07, 8'hFF, 8'hFF, 8'h0F, 8'h0F};
	logic dir, tmr, ex, own, eo, eout, lvl, csel, xm;
	logic [2:0] fn, om;
	logic [1:0] te, de, cs;
	logic [3:0] d6, q6, e6, o6, v6, lv6;

	pfps_top DUT (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.opmode_pin(opmode_pin), .timer3_b_out(timer3_b_out),
		.pulse_trigger(pulse_trigger), .timer3_capture_b(cap),
		.dma0_end(dma0_end), .dma1_end(dma1_end),
		.chip_select_four_n(sel_four_n),
		.chip_select_five_n(sel_five_n),
		.dma0_request(req0), .dma1_request(req1), .p21_in(p21_in),
		.p21(p21), .p6_in(p6_in), .p6(p6));

	pfps_pin_model PINS (.p21(p21), .p6(p6), .ext21(ext21), .ext6(ext6),
		.p21_in(p21_in), .p6_in(p6_in));

	// Free-running 10 MHz clock
	initial begin
		forever #50 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Compare and report
	// ------------------------------------------------------------
	task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t rdata got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_pin(input logic [9:0] got, input logic [9:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t pins got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checks=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Register port master
	// ------------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
	endtask

	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	// Read with a masked expectation noted for the monitor
	task automatic rdx(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] k);
		exp_q.push_back(e);
		msk_q.push_back(k);
		bus(1'b0, a, 8'h00);
	endtask

	// Read data stand one cycle after the strobe, zero otherwise
	always @(posedge clk) rd_d <= rd;
	always @(negedge clk) begin
		if (rd_d) begin
			m = msk_q.pop_front();
			cmp_rd(rdata & m, exp_q.pop_front());
		end else if (nrst) begin
			cmp_rd(rdata, 8'h00);
		end
	end

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			final_report();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(22));
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		// Reset values, unmapped address included
		for (int a = 0; a < 13; a++) rdx(8'(a), 8'h00, 8'hFF);
		// Implemented bits read back, upper bits zero
		foreach (wa[i]) begin
			bus(1'b1, wa[i], 8'hFF);
			rdx(wa[i], wm[i], 8'hFF);
		end
		foreach (wa[i]) bus(1'b1, wa[i], 8'h00);
		// Write strobe ignored while the enable is low
		ce <= 1'b0;
		bus(1'b1, OFS_P2_DATA, 8'($urandom) | 8'h01);
		ce <= 1'b1;
		rdx(OFS_P2_DATA, 8'h00, 8'hFF);
		// Trigger beats a same-cycle write of the output data
		nd = 8'($urandom);
		bus(1'b1, OFS_PULSE_EN, 8'hFF);
		bus(1'b1, OFS_PULSE_NEXT, nd);
		pulse_trigger <= 1'b1;
		bus(1'b1, OFS_PULSE_OUT, ~nd);
		pulse_trigger <= 1'b0;
		rdx(OFS_PULSE_OUT, nd, 8'hFF);
		idle(2);
		// Port 2 bit 1 over modes 0 to 3, every control and clear code
		for (int md = 0; md < 4; md++) begin
			for (int io = 0; io < 16; io++) begin
				for (int cl = 0; cl < 8; cl++) begin
					en = 8'($urandom);
					nd = 8'($urandom);
					pod = 8'($urandom);
					pd = 8'($urandom);
					dir = 1'($urandom);
					tmr = 1'($urandom);
					ex = 1'($urandom);
					bus(1'b1, OFS_TMR3_MODE, 8'(md));
					bus(1'b1, OFS_TMR3_IOCTL, 8'(io));
					bus(1'b1, OFS_TMR3_CTRL, 8'(cl));
					bus(1'b1, OFS_PULSE_EN, en);
					bus(1'b1, OFS_PULSE_NEXT, nd);
					bus(1'b1, OFS_PULSE_OUT, pod);
					bus(1'b1, OFS_P2_DIR, {6'h00, dir, 1'b0});
					bus(1'b1, OFS_P2_DATA, pd);
					timer3_b_out <= tmr;
					ext21 <= ex;
					idle(1);
					// Trigger only once the pin setup is quiet
					pulse_trigger <= 1'b1;
					@(posedge clk);
					pulse_trigger <= 1'b0;
					idle(5);
					pod = (pod & ~en) | (nd & en);
					own = (md == 0 && io[3] == 0 && io[1:0] != 0) ||
						(md == 3 && io[1:0] != 0 && cl != 2);
					fn = own ? 3'h4 : !dir ? 3'h0 : !en[1] ? 3'h1 : 3'h2;
					eo = own || dir;
					eout = own ? tmr : en[1] ? pod[1] : pd[1];
					lvl = eo ? eout : ex;
					csel = md == 0 && io[3:2] == 2;
					@(negedge clk);
					cmp_pin({7'h00, p21.oe, p21.out & p21.oe, cap},
						{7'h00, eo, eout & eo, csel & lvl});
					@(posedge clk);
					rdx(OFS_PULSE_OUT, pod, 8'hFF);
					rdx(OFS_PIN_STAT, {fn, 5'h00}, 8'hE0);
					idle(1);
				end
			end
		end
		// Port 6 pins over modes 4 to 7
		for (int k = 0; k < 64; k++) begin
			om = 3'(4 + $urandom % 4);
			d6 = 4'($urandom);
			q6 = 4'($urandom);
			e6 = 4'($urandom);
			te = 2'($urandom);
			de = 2'($urandom);
			cs = 2'($urandom);
			opmode_pin <= om;
			ext6 <= e6;
			{dma1_end, dma0_end} <= de;
			{sel_five_n, sel_four_n} <= cs;
			bus(1'b1, OFS_P6_DIR, {4'h0, d6});
			bus(1'b1, OFS_P6_DATA, {4'h0, q6});
			bus(1'b1, OFS_DMA_END, {6'h00, te});
			idle(6);
			xm = om != 3'h7;
			o6 = {te[1] | d6[3], d6[2], te[0] | d6[1], d6[0]};
			v6[3] = te[1] ? !de[1] : q6[3];
			v6[2] = q6[2];
			v6[1] = te[0] ? !de[0] : (xm ? cs[1] : q6[1]);
			v6[0] = xm ? cs[0] : q6[0];
			lv6 = (o6 & v6) | (~o6 & e6);
			@(negedge clk);
			cmp_pin({p6.oe, p6.out & p6.oe, req1, req0},
				{o6, v6 & o6, lv6[2], lv6[0]});
			@(posedge clk);
		end
		idle(3);
		final_report();
	end
endmodule
